// file: rtl/asrm_host.sv
// Summary of operation
// - single-port read: select high, read level
// - single-port write: select held, read/write pulsed low
// - single-port write: read/write low, select pulsed
// - dual-port read: select and read enable high
// - dual-port write: select held, write enable pulsed
// - dual-port write: write enable held, select pulsed
// - never read and write same dual-port address
`timescale 1ns/1ps
module asrm_host
  import asrm_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // command from user logic
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_dual,
  input  wire logic              cmd_rd,
  input  wire logic              cmd_wr,
  input  wire logic              cmd_method2,
  input  wire logic [ADDR_W-1:0] cmd_raddr,
  input  wire logic [ADDR_W-1:0] cmd_waddr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  // answer to user logic
  output logic                   rsp_done,
  output logic                   rsp_err,
  output logic      [DATA_W-1:0] rsp_rdata,
  // single-port macro pins
  output logic                   sp_cs,
  output logic                   sp_rw,
  output logic      [ADDR_W-1:0] shared_address,
  output logic      [DATA_W-1:0] sp_write_data_in,
  input  wire logic [DATA_W-1:0] sp_read_data_out,
  // dual-port macro pins
  output logic                   dp_cs,
  output logic                   dp_rd,
  output logic                   dp_wr,
  output logic      [ADDR_W-1:0] fetch_address,
  output logic      [ADDR_W-1:0] store_address,
  output logic      [DATA_W-1:0] dp_write_data_in,
  input  wire logic [DATA_W-1:0] dp_read_data_out
);
  asrm_state_t       state_r;
  asrm_state_t       state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic              dual_r;
  logic              do_rd_r;
  logic              do_wr_r;
  logic              m2_r;
  logic              bad_cmd;
  logic              cnt_zero;
  logic [DATA_W-1:0] sp_rd_sync;
  logic [DATA_W-1:0] dp_rd_sync;
  logic              sp_settled;
  logic              dp_settled;
  logic              rd_settled;
  logic              dual_e;
  logic              rd_e;
  logic              m2_e;

  // read data from each macro is asynchronous to sys_clk
  asrm_sync #(.W(DATA_W)) u_sp_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (sp_read_data_out),
    .sync_out (sp_rd_sync),
    .settled  (sp_settled)
  );

  asrm_sync #(.W(DATA_W)) u_dp_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in (dp_read_data_out),
    .sync_out (dp_rd_sync),
    .settled  (dp_settled)
  );

  // refuse empty commands, a combined single-port access, an overlapped access to one word,
  // and addresses past the deepest macro shape
  always_comb begin
    bad_cmd = 1'b0;
    if (!cmd_rd && !cmd_wr) bad_cmd = 1'b1;
    if (!cmd_dual && cmd_rd && cmd_wr) bad_cmd = 1'b1;
    if (cmd_dual && cmd_rd && cmd_wr && (cmd_raddr == cmd_waddr)) bad_cmd = 1'b1;
    if ((32'(cmd_raddr) >= DEPTH_MAX) || (32'(cmd_waddr) >= DEPTH_MAX)) bad_cmd = 1'b1;
  end

  assign cnt_zero   = (cnt_r == '0);
  assign rd_settled = dual_r ? dp_settled : sp_settled;

  // on the take edge the latches still hold the previous command, so the pins
  // follow the incoming one; otherwise a stale mode drives a stray strobe
  assign dual_e = (state_r == ST_IDLE) ? cmd_dual : dual_r;
  assign rd_e   = (state_r == ST_IDLE) ? cmd_rd : do_rd_r;
  assign m2_e   = (state_r == ST_IDLE) ? (cmd_method2 && !(cmd_dual && cmd_rd)) : m2_r;

  // sequencer: setup, write pulse, hold, then read access
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_valid && !bad_cmd) state_nxt = ST_SETUP;
      end
      ST_SETUP: begin
        if (cnt_zero) state_nxt = do_wr_r ? ST_PULSE : ST_ACCESS;
      end
      ST_PULSE: begin
        if (cnt_zero) state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        // read only after the write has closed, so no forwarding is needed
        if (cnt_zero) state_nxt = do_rd_r ? ST_ACCESS : ST_DONE;
      end
      ST_ACCESS: begin
        if (cnt_zero && rd_settled) state_nxt = ST_DONE;
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) state_r <= ST_IDLE;
    else       state_r <= state_nxt;
  end

  // wait counter, loaded on each state entry
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      case (state_nxt)
        ST_SETUP:  cnt_r <= AS_CYC - CNT_W'(1);
        ST_PULSE:  cnt_r <= WP_CYC - CNT_W'(1);
        ST_HOLD:   cnt_r <= HLD_CYC - CNT_W'(1);
        ST_ACCESS: cnt_r <= RD_CYC - CNT_W'(1);
        default:   cnt_r <= '0;
      endcase
    end else if (!cnt_zero) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  // latch the command; method 2 cannot pulse select while a read holds it high
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dual_r  <= 1'b0;
      do_rd_r <= 1'b0;
      do_wr_r <= 1'b0;
      m2_r    <= 1'b0;
    end else if (state_r == ST_IDLE && cmd_valid && !bad_cmd) begin
      dual_r  <= cmd_dual;
      do_rd_r <= cmd_rd;
      do_wr_r <= cmd_wr;
      m2_r    <= cmd_method2 && !(cmd_dual && cmd_rd);
    end
  end

  // addresses and write data held stable from setup through hold
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      shared_address   <= '0;
      fetch_address    <= '0;
      store_address    <= '0;
      sp_write_data_in <= '0;
      dp_write_data_in <= '0;
    end else if (state_r == ST_IDLE && cmd_valid && !bad_cmd) begin
      if (cmd_dual) begin
        fetch_address    <= cmd_raddr;
        store_address    <= cmd_waddr;
        dp_write_data_in <= cmd_wdata;
      end else begin
        shared_address   <= cmd_wr ? cmd_waddr : cmd_raddr;
        sp_write_data_in <= cmd_wdata;
      end
    end
  end

  // single-port pins; outside a command select is low, the wait state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sp_cs <= 1'b0;
      sp_rw <= SP_RW_IDLE;
    end else if (dual_e || state_nxt == ST_IDLE || state_nxt == ST_DONE) begin
      sp_cs <= 1'b0;
      sp_rw <= SP_RW_IDLE;
    end else if (rd_e) begin
      sp_cs <= 1'b1;
      sp_rw <= 1'b1;
    end else if (m2_e) begin
      sp_rw <= 1'b0;
      sp_cs <= (state_nxt == ST_PULSE);
    end else begin
      sp_cs <= 1'b1;
      sp_rw <= (state_nxt != ST_PULSE);
    end
  end

  // dual-port pins; falling edge of the closing pulse stores the word
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dp_cs <= 1'b0;
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
    end else if (!dual_e || state_nxt == ST_IDLE || state_nxt == ST_DONE) begin
      dp_cs <= 1'b0;
      dp_rd <= 1'b0;
      dp_wr <= 1'b0;
    end else if (m2_e) begin
      dp_rd <= 1'b0;
      dp_wr <= 1'b1;
      dp_cs <= (state_nxt == ST_PULSE);
    end else begin
      dp_cs <= 1'b1;
      dp_rd <= rd_e;
      dp_wr <= do_wr_r && (state_nxt == ST_PULSE);
    end
  end

  // answer side; read data taken only from the settled synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_ready <= 1'b0;
      rsp_done  <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      cmd_ready <= (state_nxt == ST_IDLE) && !(state_r == ST_IDLE && cmd_valid);
      rsp_done  <= (state_nxt == ST_DONE);
      rsp_err   <= (state_r == ST_IDLE) && cmd_valid && bad_cmd;
      if (state_r == ST_ACCESS && state_nxt == ST_DONE) begin
        rsp_rdata <= dual_r ? dp_rd_sync : sp_rd_sync;
      end
    end
  end
endmodule : asrm_host

// file: rtl/asrm_pkg.sv
package asrm_pkg;
  // pin widths of the largest macro shape, 256 words x 32 bits
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DEPTH_MIN    = 8;
  localparam int unsigned DEPTH_MAX    = 256;
  localparam int unsigned DEPTH_STEP   = 4;
  localparam int unsigned CNT_W        = 3;

  // clock and worst-case macro timing, in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned T_ACC_PS      = 24260;  // slowest address/select access time
  localparam int unsigned T_WP_PS       = 7210;   // longest write pulse width
  localparam int unsigned T_AS_PS       = 1550;   // longest address setup
  localparam int unsigned T_AH_PS       = 2160;   // address hold after pulse
  localparam int unsigned T_DH_PS       = 6190;   // data hold after pulse

  // least times round up, never below one cycle
  localparam int unsigned ACC_CYC_I = (T_ACC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WP_CYC_I  = (T_WP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned AS_CYC_I  = (T_AS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HLD_PS    = (T_AH_PS > T_DH_PS) ? T_AH_PS : T_DH_PS;
  localparam int unsigned HLD_CYC_I = (HLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // read data crosses three flops before it is trusted
  localparam int unsigned SYNC_CYC  = 3;

  localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((ACC_CYC_I < 1) ? 1 : ACC_CYC_I);
  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'((WP_CYC_I < 1) ? 1 : WP_CYC_I);
  localparam logic [CNT_W-1:0] AS_CYC  = CNT_W'((AS_CYC_I < 1) ? 1 : AS_CYC_I);
  localparam logic [CNT_W-1:0] HLD_CYC = CNT_W'((HLD_CYC_I < 1) ? 1 : HLD_CYC_I);
  localparam logic [CNT_W-1:0] RD_CYC  = CNT_W'(((ACC_CYC_I < 1) ? 1 : ACC_CYC_I) + SYNC_CYC);

  // idle pin levels
  localparam logic SP_RW_IDLE = 1'b1;  // read level, so no stray write edge

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_SETUP  = 6'b00_0010,
    ST_PULSE  = 6'b00_0100,
    ST_HOLD   = 6'b00_1000,
    ST_ACCESS = 6'b01_0000,
    ST_DONE   = 6'b10_0000
  } asrm_state_t;
endpackage : asrm_pkg

// file: rtl/asrm_sync.sv
`timescale 1ns/1ps
module asrm_sync #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // asynchronous word in, settled word out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out,
  output logic              settled
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // three stages; only the second stage reads the first
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // word counts once the second and third stages agree
  assign sync_out = s3_r;
  assign settled  = (s2_r == s3_r);
endmodule : asrm_sync

// file: verif/asrm_host_bench.sv
`timescale 1ns/1ps
module asrm_host_bench;
  import asrm_pkg::*;
  logic              sys_clk, rstn, cmd_valid, cmd_ready, cmd_dual, cmd_rd, cmd_wr, cmd_method2;
  logic              rsp_done, rsp_err, sp_cs, sp_rw, dp_cs, dp_rd, dp_wr;
  logic [ADDR_W-1:0] cmd_raddr, cmd_waddr, shared_address, fetch_address, store_address;
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata, sp_wd, sp_rd, dp_wd, dp_rd_q;
  logic [DATA_W-1:0] sp_sh [256];
  logic [DATA_W-1:0] dp_sh [256];
  logic [33:0]       exp_q [$];
  logic [33:0]       e;
  logic [31:0]       rnd;
  integer            seed = 32'hda1f3222;
  int                fail_count, num_checks, cyc;

  asrm_host i_asrm_host (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_dual(cmd_dual), .cmd_rd(cmd_rd), .cmd_wr(cmd_wr), .cmd_method2(cmd_method2), .cmd_raddr(cmd_raddr),
    .cmd_waddr(cmd_waddr), .cmd_wdata(cmd_wdata), .rsp_done(rsp_done), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .sp_cs(sp_cs), .sp_rw(sp_rw), .shared_address(shared_address), .sp_write_data_in(sp_wd),
    .sp_read_data_out(sp_rd), .dp_cs(dp_cs), .dp_rd(dp_rd), .dp_wr(dp_wr), .fetch_address(fetch_address),
    .store_address(store_address), .dp_write_data_in(dp_wd), .dp_read_data_out(dp_rd_q));
  asrm_ram_model i_asrm_ram_model (.sp_cs(sp_cs), .sp_rw(sp_rw), .shared_address(shared_address),
    .sp_write_data_in(sp_wd), .sp_read_data_out(sp_rd), .dp_cs(dp_cs), .dp_rd(dp_rd), .dp_wr(dp_wr),
    .fetch_address(fetch_address), .store_address(store_address), .dp_write_data_in(dp_wd),
    .dp_read_data_out(dp_rd_q));

  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // one command; the expectation comes from the bench's own copy of both memories
  task op(input logic d, input logic r, input logic w, input logic m2, input logic [7:0] ra,
          input logic [7:0] wa, input logic [31:0] wd);
    logic err;
    err = (!r && !w) || (!d && r && w) || (d && r && w && ra == wa);
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    {cmd_dual, cmd_rd, cmd_wr, cmd_method2, cmd_raddr, cmd_waddr, cmd_wdata} = {d, r, w, m2, ra, wa, wd};
    cmd_valid = 1'b1;
    exp_q.push_back({r && !err, err, d ? dp_sh[ra] : sp_sh[ra]});
    if (!err && w && d) dp_sh[wa] = wd;
    if (!err && w && !d) sp_sh[wa] = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    @(negedge sys_clk);
  endtask : op

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // scoreboard side: every answer takes the oldest note
  always @(negedge sys_clk) begin
    if (rsp_done === 1'b1 || rsp_err === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 34'h3_ffff_ffff;
      check({31'h0000_0000, rsp_err}, {31'h0000_0000, e[32]});
      if (e[33]) check(rsp_rdata, e[31:0]);
    end
  end

  // hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    {rstn, cmd_valid, cmd_dual, cmd_rd, cmd_wr, cmd_method2} = 6'h00;
    {cmd_raddr, cmd_waddr, cmd_wdata} = 48'h0000_0000_0000;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    // one edge after release: ready up, no answer, both macros in their wait state
    @(negedge sys_clk);
    check({27'h000_0000, cmd_ready, rsp_done, rsp_err, sp_cs, dp_cs}, 32'h0000_0010);
    // fill both memories, alternating write methods, corners 0 and 255 included
    for (int a = 0; a < 256; a++) begin
      op(1'b0, 1'b0, 1'b1, a[0], 8'h00, a[7:0], $random(seed));
      op(1'b1, 1'b0, 1'b1, a[1], 8'h00, a[7:0], $random(seed));
    end
    // refused combined access to one address must leave the word alone
    op(1'b1, 1'b1, 1'b1, 1'b0, 8'h5a, 8'h5a, 32'hdead_beef);
    op(1'b1, 1'b1, 1'b0, 1'b0, 8'h5a, 8'h00, 32'h0000_0000);
    // random back-to-back mix, including refusals and combined access
    for (int i = 0; i < 300; i++) begin
      rnd = $random(seed);
      op(rnd[0], rnd[1], rnd[2], rnd[3], rnd[15:8], rnd[23:16], $random(seed));
    end
    repeat (20) @(negedge sys_clk);
    check({31'h0000_0000, exp_q.size() == 0}, 32'h0000_0001);
    summarize();
  end
endmodule : asrm_host_bench

// file: verif/asrm_host_monitor.sv
`timescale 1ns/1ps
module asrm_host_monitor
  import asrm_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rstn,
  // answer to user logic
  input wire logic              rsp_done,
  input wire logic              rsp_err,
  // single-port pins
  input wire logic              sp_cs,
  input wire logic              sp_rw,
  input wire logic [ADDR_W-1:0] shared_address,
  input wire logic [DATA_W-1:0] sp_write_data_in,
  // dual-port pins
  input wire logic              dp_cs,
  input wire logic              dp_rd,
  input wire logic              dp_wr,
  input wire logic [ADDR_W-1:0] fetch_address,
  input wire logic [ADDR_W-1:0] store_address,
  input wire logic [DATA_W-1:0] dp_write_data_in
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // write pulses last one cycle, the other strobe held across the trailing edge
  property p_sp_m1; $fell(sp_rw) && sp_cs |=> sp_cs && sp_rw; endproperty
  property p_sp_m2; $rose(sp_cs) && !sp_rw |=> !sp_cs && !sp_rw; endproperty
  property p_dp_m1; $rose(dp_wr) && dp_cs |=> dp_cs && !dp_wr; endproperty
  property p_dp_m2; $rose(dp_cs) && dp_wr |=> !dp_cs && dp_wr; endproperty
  // address and data must not move at the trailing edge, or the wrong word is stored
  property p_sp_hold;
    sp_cs && !sp_rw |=> $stable(shared_address) && $stable(sp_write_data_in);
  endproperty
  property p_dp_hold;
    dp_cs && dp_wr |=> $stable(store_address) && $stable(dp_write_data_in);
  endproperty
  property p_rd_end; $fell(sp_cs) && sp_rw |-> rsp_done; endproperty
  property p_dp_rd; dp_rd |-> dp_cs; endproperty
  property p_dp_same; dp_cs && dp_rd && dp_wr |-> fetch_address != store_address; endproperty
  property p_err_quiet; rsp_err |-> !sp_cs && !dp_cs; endproperty
  // combined access: read only trusted after the write completes
  property p_dp_wait; $fell(dp_wr) && dp_rd |-> !rsp_done [*5]; endproperty

  a_sp_m1: assert property (p_sp_m1) else $error("sp rw pulse malformed");
  a_sp_m2: assert property (p_sp_m2) else $error("sp select pulse malformed");
  a_dp_m1: assert property (p_dp_m1) else $error("dp write pulse malformed");
  a_dp_m2: assert property (p_dp_m2) else $error("dp select pulse malformed");
  a_sp_hold: assert property (p_sp_hold) else $error("sp address or data moved");
  a_dp_hold: assert property (p_dp_hold) else $error("dp address or data moved");
  a_rd_end: assert property (p_rd_end) else $error("sp access ended without done");
  a_dp_rd: assert property (p_dp_rd) else $error("dp read enable without select");
  a_dp_same: assert property (p_dp_same) else $error("dp read and write same address");
  a_err_quiet: assert property (p_err_quiet) else $error("refused command moved pins");
  a_dp_wait: assert property (p_dp_wait) else $error("dp read done too early");

  c_dp_both: cover property ($rose(dp_wr) && dp_rd);
  c_sp_m2: cover property ($rose(sp_cs) && !sp_rw);
  c_err: cover property (rsp_err);
endmodule : asrm_host_monitor

bind asrm_host asrm_host_monitor i_mon (.sys_clk(sys_clk), .rstn(rstn), .rsp_done(rsp_done),
  .rsp_err(rsp_err), .sp_cs(sp_cs), .sp_rw(sp_rw), .shared_address(shared_address),
  .sp_write_data_in(sp_write_data_in), .dp_cs(dp_cs), .dp_rd(dp_rd), .dp_wr(dp_wr),
  .fetch_address(fetch_address), .store_address(store_address), .dp_write_data_in(dp_write_data_in));

// file: verif/asrm_ram_model.sv
`timescale 1ns/1ps
module asrm_ram_model
  import asrm_pkg::*;
(
  // single-port macro
  input wire logic              sp_cs,
  input wire logic              sp_rw,
  input wire logic [ADDR_W-1:0] shared_address,
  input wire logic [DATA_W-1:0] sp_write_data_in,
  output logic     [DATA_W-1:0] sp_read_data_out,
  // dual-port macro
  input wire logic              dp_cs,
  input wire logic              dp_rd,
  input wire logic              dp_wr,
  input wire logic [ADDR_W-1:0] fetch_address,
  input wire logic [ADDR_W-1:0] store_address,
  input wire logic [DATA_W-1:0] dp_write_data_in,
  output logic     [DATA_W-1:0] dp_read_data_out
);
  // largest shape, so any 8-bit address is real
  logic [DATA_W-1:0] sp_mem [256];
  logic [DATA_W-1:0] dp_mem [256];

  // stores happen only at a pulse's trailing edge
  always @(posedge sp_rw) if (sp_cs) sp_mem[shared_address] = sp_write_data_in;
  always @(negedge sp_cs) if (!sp_rw) sp_mem[shared_address] = sp_write_data_in;
  always @(negedge dp_wr) if (dp_cs) dp_mem[store_address] = dp_write_data_in;
  always @(negedge dp_cs) if (dp_wr) dp_mem[store_address] = dp_write_data_in;

  // outside a read the output is garbage: inverted word, never a stale match
  assign sp_read_data_out = (sp_cs && sp_rw) ? sp_mem[shared_address] : ~sp_mem[shared_address];
  assign dp_read_data_out = (dp_cs && dp_rd) ? dp_mem[fetch_address] : ~dp_mem[fetch_address];
endmodule : asrm_ram_model
